/* core/lamp_pulse_consts.svh */
`ifndef LAMP_PULSE_CONSTS_SVH
`define LAMP_PULSE_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FREQ_SEL_IDX      8'h18
`define DUTY_CTRL_IDX     8'h19

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PUMP_FREQ_LSB     0
`define CHARGE_FREQ_LSB   3
`define PUMP_DUTY_LSB     0
`define CHARGE_DUTY_LSB   3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
// Pump tap 010 (fast/256), charge tap 10 (512 Hz)
`define FREQ_SEL_RST      8'h12
// Pump duty 110 (7/8), charge duty 000 (1/8)
`define DUTY_CTRL_RST     8'h06

// ----------------------------------------------------------------
// Divider chain figures
// ----------------------------------------------------------------
// Code 000 gives fast/1024, i.e. a 2^10 period
`define PUMP_LOG2_BASE    4'hA
// Charge code 00 gives slow/256, i.e. a 2^8 period
`define CHARGE_LOG2_BASE  4'h8
`define FAST_CHAIN_W      10
`define SLOW_CHAIN_W      8

`endif

/* core/lamp_pulse_pkg.sv */
package lamp_pulse_pkg;

    typedef struct packed {
        logic [7:0] freq_sel;
        logic [7:0] duty_ctrl;
    } lamp_regs_t;

    typedef struct packed {
        lamp_regs_t  regs;
        logic        ack;
        logic [31:0] rdat;
        logic [9:0]  fast_cnt;
        logic [2:0]  slow_sync;
        logic        slow_level;
        logic [7:0]  slow_cnt;
        logic        pump;
        logic        charge;
    } lamp_state_t;

endpackage

/* core/lamp_duty_gen.sv */
`timescale 1ns/1ps
`default_nettype none

// Duty slicer: the top three bits of the active period window give
// the current eighth; the output is high while that eighth is not
// above the duty code, so code 111 is high throughout.
module lamp_duty_gen #(
    parameter int W = 10
) (
    input  wire logic [W-1:0] i_cnt,
    input  wire logic [3:0]   i_log2,
    input  wire logic [2:0]   i_duty,
    output logic              o_high
);

    logic [W-1:0] shifted;
    logic [2:0]   eighth;

    always_comb begin
        shifted = i_cnt >> (i_log2 - 4'h3);
        eighth  = shifted[2:0];
        o_high  = (eighth <= i_duty);
    end

endmodule

`default_nettype wire

/* core/lamp_pump_pulse_control.sv */
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

`include "lamp_pulse_consts.svh"

module lamp_pump_pulse_control (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_slow_clock_32k,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [9:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_lamp_pump_pulse,
    output logic             o_lamp_charge_clock
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    localparam logic [9:0] FREQ_ADR = {`FREQ_SEL_IDX, 2'b00};
    localparam logic [9:0] DUTY_ADR = {`DUTY_CTRL_IDX, 2'b00};

    // Both registers share one byte lane; a hit code of 00 means the
    // address is unmapped and the access is still acknowledged.
    function automatic logic [1:0] decode(input logic [9:0] adr);
        logic [1:0] hit;
        hit = 2'b00;
        if (adr == FREQ_ADR) begin
            hit = 2'b01;
        end else if (adr == DUTY_ADR) begin
            hit = 2'b10;
        end
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    // Upper bytes always read zero so software may mask nothing.
    function automatic logic [31:0] readback(
        input logic [1:0]                 sel_hit,
        input lamp_pulse_pkg::lamp_regs_t regs
    );
        logic [31:0] val;
        val = 32'h0000_0000;
        if (sel_hit == 2'b01) begin
            val = {24'h00_0000, regs.freq_sel};
        end else if (sel_hit == 2'b10) begin
            val = {24'h00_0000, regs.duty_ctrl};
        end
        return val;
    endfunction

    // ------------------------------------------------------------
    // Reset state
    // ------------------------------------------------------------
    // Constants only: the asynchronous branch must not sample
    // anything that moves while reset is asserted.
    localparam lamp_pulse_pkg::lamp_regs_t RST_REGS = '{
        freq_sel  : `FREQ_SEL_RST,
        duty_ctrl : `DUTY_CTRL_RST
    };

    localparam lamp_pulse_pkg::lamp_state_t RST_STATE = '{
        regs       : RST_REGS,
        ack        : 1'b0,
        rdat       : 32'h0000_0000,
        fast_cnt   : 10'h000,
        slow_sync  : 3'h0,
        slow_level : 1'b0,
        slow_cnt   : 8'h00,
        pump       : 1'b0,
        charge     : 1'b0
    };

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lamp_pulse_pkg::lamp_state_t s_q;
    lamp_pulse_pkg::lamp_state_t s_d;

    logic [1:0] hit;
    logic       req;
    logic       wr_lane;
    logic [2:0] pump_tap;
    logic [1:0] charge_tap;
    logic [2:0] pump_duty;
    logic [2:0] charge_duty;
    logic [3:0] pump_log2;
    logic [3:0] charge_log2;
    logic       pump_hi;
    logic       charge_hi;
    logic       slow_agree;
    logic       slow_rise;

    // ------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------
    always_comb begin
        pump_tap    = s_q.regs.freq_sel[`PUMP_FREQ_LSB +: 3];
        charge_tap  = s_q.regs.freq_sel[`CHARGE_FREQ_LSB +: 2];
        pump_duty   = s_q.regs.duty_ctrl[`PUMP_DUTY_LSB +: 3];
        charge_duty = s_q.regs.duty_ctrl[`CHARGE_DUTY_LSB +: 3];
        // Each step up in code halves the divisor
        pump_log2   = `PUMP_LOG2_BASE - {1'b0, pump_tap};
        charge_log2 = `CHARGE_LOG2_BASE - {2'b00, charge_tap};
    end

    // ------------------------------------------------------------
    // Duty slicers
    // ------------------------------------------------------------
    lamp_duty_gen #(
        .W (`FAST_CHAIN_W)
    ) u_pump_duty (
        .i_cnt  (s_q.fast_cnt),
        .i_log2 (pump_log2),
        .i_duty (pump_duty),
        .o_high (pump_hi)
    );

    lamp_duty_gen #(
        .W (`SLOW_CHAIN_W)
    ) u_charge_duty (
        .i_cnt  (s_q.slow_cnt),
        .i_log2 (charge_log2),
        .i_duty (charge_duty),
        .o_high (charge_hi)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        hit = decode(i_wb_adr);
        req = i_wb_cyc && i_wb_stb && !s_q.ack;
        wr_lane = i_wb_we && i_wb_sel[0];

        // Bus slave: one wait state, ack for a single cycle.
        // Unmapped addresses are acknowledged and read as zero.
        s_d.ack  = req;
        s_d.rdat = 32'h0000_0000;
        if (req) begin
            s_d.rdat = readback(hit, s_q.regs);
            if (hit == 2'b01) begin
                if (wr_lane) begin
                    s_d.regs.freq_sel = i_wb_dat[7:0];
                end
            end else if (hit == 2'b10) begin
                if (wr_lane) begin
                    s_d.regs.duty_ctrl = i_wb_dat[7:0];
                end
            end
        end

        // Fast chain runs on every system clock. A tap change does
        // not restart the chain, so the first period after it may be
        // short; the lamp stage tolerates this, a reset was not worth it.
        s_d.fast_cnt = s_q.fast_cnt + 10'h001;

        // Slow pin: three stages, a change counts once the second
        // and third agree, which rejects one-cycle glitches.
        s_d.slow_sync = {s_q.slow_sync[1:0], i_slow_clock_32k};
        slow_agree = (s_q.slow_sync[1] == s_q.slow_sync[2]);
        slow_rise  = slow_agree && s_q.slow_sync[2] && !s_q.slow_level;
        if (slow_agree) begin
            s_d.slow_level = s_q.slow_sync[2];
        end
        if (slow_rise) begin
            s_d.slow_cnt = s_q.slow_cnt + 8'h01;
        end

        // Outputs registered so they never glitch on tap changes
        s_d.pump   = pump_hi;
        s_d.charge = charge_hi;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        o_wb_dat            = s_q.rdat;
        o_wb_ack            = s_q.ack;
        o_lamp_pump_pulse   = s_q.pump;
        o_lamp_charge_clock = s_q.charge;
    end

endmodule

`default_nettype wire

/* verif/lamp_pulse_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module lamp_pulse_sva (
    input wire logic        i_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_wb_we,
    input wire logic [9:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_lamp_pump_pulse,
    input wire logic        o_lamp_charge_clock
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // Shadows follow writes at the ack edge, one edge after the design
    logic [7:0] f_q;
    logic [7:0] d_q;
    wire logic wr = o_wb_ack && i_wb_we && i_wb_sel[0];
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            f_q <= 8'h12;
            d_q <= 8'h06;
        end else if (wr && i_wb_adr == 10'h060) begin
            f_q <= i_wb_dat[7:0];
        end else if (wr && i_wb_adr == 10'h064) begin
            d_q <= i_wb_dat[7:0];
        end
    end
    AST_ACK_DROP: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    AST_RD_FREQ: assert property (
        o_wb_ack && !i_wb_we && i_wb_adr == 10'h060
        |-> o_wb_dat == {24'h0, f_q})
        else $error("frequency select read wrong");
    AST_RD_DUTY: assert property (
        o_wb_ack && !i_wb_we && i_wb_adr == 10'h064
        |-> o_wb_dat == {24'h0, d_q})
        else $error("duty control read wrong");
    AST_PUMP_HOLD: assert property (
        d_q[2:0] == 3'h7 && $past(d_q[2:0]) == 3'h7
        |-> o_lamp_pump_pulse)
        else $error("pump not held high");
    AST_CHG_HOLD: assert property (
        d_q[5:3] == 3'h7 && $past(d_q[5:3]) == 3'h7
        |-> o_lamp_charge_clock)
        else $error("charge clock not held high");
    // Not while ack stands: the design applies a write one edge
    // before the shadows do
    AST_PUMP_FAST: assert property (
        f_q[2:0] == 3'h7 && d_q[2:0] == 3'h0 && !o_wb_ack
        && $stable(f_q) && $stable(d_q) && $rose(o_lamp_pump_pulse)
        |=> !o_lamp_pump_pulse)
        else $error("pump high too long at fastest tap");
endmodule
bind lamp_pump_pulse_control lamp_pulse_sva chk_u (
    .i_clk, .i_sys_rst, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
    .o_wb_dat, .o_wb_ack, .o_lamp_pump_pulse, .o_lamp_charge_clock);
`default_nettype wire

/* verif/lamp_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Lamp stage input: measures last high time and period of its drive
module lamp_stage_model (
    input  wire logic i_clk,
    input  wire logic i_drive,
    output int        o_hi,
    output int        o_per,
    output int        o_n
);
    logic prev = 1'b0;
    int   c    = 0;
    int   h    = 0;
    initial o_n = 0;
    always @(posedge i_clk) begin
        prev <= i_drive;
        if (i_drive && !prev) begin
            o_per <= c;
            o_hi  <= h;
            o_n   <= o_n + 1;
            c     <= 1;
            h     <= 1;
        end else begin
            c <= c + 1;
            h <= h + int'(i_drive);
        end
    end
endmodule
`default_nettype wire

/* verif/test_lamp_pump_pulse_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_lamp_pump_pulse_control;
    logic clk = 0, rst = 1, slow = 0, cyc = 0, stb = 0, we = 0, ack, pump, chg;
    logic [9:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] dat = '0, rdat;
    logic [2:0] sc = '0, pd, cd;
    logic [7:0] lf = 8'h33, q;
    int n_fail = 0, check_count = 0, ph, pp, pn, ch, cp, cn, k;
    initial forever #5 clk = ~clk;
    // Slow pin runs at clk/8 so charge periods stay short
    always @(posedge clk) begin
        sc <= sc + 3'h1;
        slow <= sc[2];
    end
    lamp_pump_pulse_control dut_u (.i_clk(clk), .i_sys_rst(rst),
        .i_slow_clock_32k(slow), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_lamp_pump_pulse(pump),
        .o_lamp_charge_clock(chg));
    lamp_stage_model pm_u (.i_clk(clk), .i_drive(pump), .o_hi(ph), .o_per(pp), .o_n(pn));
    lamp_stage_model cm_u (.i_clk(clk), .i_drive(chg), .o_hi(ch), .o_per(cp), .o_n(cn));
    function automatic logic [7:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction
    task automatic end_sim();
        $display("fails=%0d checks=%0d", n_fail, check_count);
        if (n_fail == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, sel, dat} <= {1'b1, 1'b1, w, a, 4'hF, 24'h0, d};
        n = 0;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
        q = rdat[7:0];
        {cyc, stb} <= 2'b00;
        if (n >= 50) begin n_fail++; end_sim(); end
    endtask
    // Waits for three fresh rises so the last period is a full one
    task automatic rise(input bit s);
        int m, n;
        m = s ? cn : pn;
        n = 0;
        while ((s ? cn : pn) < m + 3 && n < 20000) begin @(posedge clk); n++; end
        if (n >= 20000) begin n_fail++; end_sim(); end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        wb(0, 10'h060, 8'h00); chk(q, 8'h12);
        wb(0, 10'h064, 8'h00); chk(q, 8'h06);
        wb(0, 10'h000, 8'h00); chk(q, 8'h00);
        rise(0); chk(pp, 256); chk(ph, 224);
        $display("reset test done");
        for (int c = 0; c < 8; c++) begin
            pd = (c == 7) ? 3'h0 : 3'(rnd() % 7);
            cd = 3'(c % 7);
            wb(1, 10'h060, {3'h0, 2'(c), 3'(c)});
            wb(1, 10'h064, {2'h0, cd, pd});
            wb(0, 10'h064, 8'h00); chk(q, {2'h0, cd, pd});
            rise(0);
            rise(1);
            chk(pp, 1024 >> c);
            chk(ph, (pd + 1) * (128 >> c));
            chk(cp, (256 >> c[1:0]) * 8);
            chk(ch, (cd + 1) * (32 >> c[1:0]) * 8);
            $display("tap test %0d done", c);
        end
        wb(1, 10'h064, 8'h3F);
        repeat (20) @(posedge clk);
        k = 0;
        repeat (64) begin @(posedge clk); k += int'(pump && chg); end
        chk(k, 64);
        $display("hold test done");
        end_sim();
    end
endmodule
`default_nettype wire
